/* File: src/cwl_config_word_loader.sv */
/*
  Configuration word loader: copies two packed flash words into volatile
  cells at power-on reset, decodes them, serves table reads and write-once writes.
  Assumes the flash answers a read after FLASH_LAT cycles and that the
  power-on indication is high only for a power-on reset.
*/
// Operation
// - zero means programmed, one means unprogrammed and selects default setting
// - configuration space starts at F80000h, reached only by table access; in_cfg_space decodes it from CWL_CFG_SPACE_LO, 800000h
// - volatile cells loaded automatically from flash words during power-on resets
// - word 1 from topmost program word, word 2 the word below
// - power-on sets all cells to one; other resets keep values, no refetch
// - each programmable bit writable once per power cycle; later writes ignored
// - word 1 bit 15 reserved kept one; bits 9 and 5 read one
// - word 1 bit 14 enables test port when one
// - word 1 bit 13 zero enables code protection
// - word 1 bit 12 zero blocks program memory writes
// - bit 11 zero debug mode, bit 10 zero emulation, else normal
// - word 1 bit 8 selects debug pin pair two when one
// - bit 7 enables watchdog; bit 6 zero windowed, needs enable
// - word 1 bit 4 selects prescale 1:128 when one, else 1:32
// - bits 3-0 select postscale ratio one to two power field
// - word 2 bit 15 enables two-speed start-up; unimplemented bits read one
// - word 2 bits 10-8 select the reset oscillator source
// - word 2 bits 7-6 control clock switching and fail-safe monitor
// - bit 5 selects clock-out pin only when primary mode is 11 or 00
// - word 2 bits 1-0 configure primary oscillator mode
// - id register: family id bits 13-6, part id bits 5-0, rest zero
`timescale 1ns/1ns
module cwl_config_word_loader #(
    parameter logic [1:0] MEM_SIZE = 2'h2,
    parameter int FLASH_LAT = 2,
    parameter logic [7:0] FAMILY_ID = cwl_pkg::CWL_FAMILY_ID_DEFAULT,
    parameter logic [5:0] PART_ID = cwl_pkg::CWL_PART_ID_DEFAULT
) (
    input wire logic clk_sys_in, // 250 MHz system clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic por_in, // high when reset cause is power-on
    output logic flash_rd_out, // flash read strobe
    output logic [23:0] flash_addr_out, // flash word address
    input wire logic [23:0] flash_data_in, // flash read data
    input wire logic flash_valid_in, // flash data valid pulse
    input wire logic tbl_rd_in, // table read strobe
    input wire logic tbl_wr_in, // table write strobe
    input wire logic [23:0] tbl_addr_in, // table address
    input wire logic [23:0] tbl_wdata_in, // table write data
    output logic [23:0] tbl_rdata_out, // table read data
    output logic tbl_ack_out, // table access done pulse
    output logic core_reset_n_out, // internal reset release
    output cwl_pkg::cwl_cfg_t cfg_out, // decoded configuration
    output logic wdt_config_error_out // windowed mode without enable
);

    initial
    begin
        if (MEM_SIZE > 2'h2 || FLASH_LAT < 1 || FLASH_LAT > 15)
        begin
            $error("cwl: unsupported parameter values");
        end
    end

    default clocking cwl_cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    ////////////////////////////////////////////////////////////////////

    typedef enum logic [2:0] {
        CWL_ST_IDLE = 3'h0,
        CWL_ST_REQ1 = 3'h1,
        CWL_ST_WAIT1 = 3'h2,
        CWL_ST_REQ2 = 3'h3,
        CWL_ST_WAIT2 = 3'h4,
        CWL_ST_DONE = 3'h5
    } cwl_state_t;

    cwl_state_t state;
    cwl_state_t next_state;
    logic [23:0] word_one;
    logic [23:0] word_two;
    logic loaded;
    logic pending_por;
    logic [23:0] written_one;
    logic [23:0] written_two;

    wire [23:0] w1_addr = (MEM_SIZE == 2'h0) ? cwl_pkg::CWL_W1_ADDR_SMALL :
                          (MEM_SIZE == 2'h1) ? cwl_pkg::CWL_W1_ADDR_MID :
                          cwl_pkg::CWL_W1_ADDR_LARGE;
    wire [23:0] w2_addr = w1_addr - cwl_pkg::CWL_W2_ADDR_STEP;

    // effective views with unimplemented and reserved bits forced
    wire [23:0] w1_view = word_one | cwl_pkg::CWL_W1_FORCE_ONE;
    wire [23:0] w2_view = word_two | cwl_pkg::CWL_W2_FORCE_ONE;
    wire [23:0] id_view = {10'h000, FAMILY_ID, PART_ID};

    wire in_cfg_space = tbl_addr_in >= cwl_pkg::CWL_CFG_SPACE_LO;
    wire hit_one = in_cfg_space && tbl_addr_in == cwl_pkg::CWL_OFS_WORD_ONE;
    wire hit_two = in_cfg_space && tbl_addr_in == cwl_pkg::CWL_OFS_WORD_TWO;
    wire hit_id = in_cfg_space && tbl_addr_in == cwl_pkg::CWL_OFS_PART_ID;

    // write-once: only cells still at one and not yet written may drop
    wire [23:0] prog_one = ~tbl_wdata_in & ~written_one &
                           ~cwl_pkg::CWL_W1_FORCE_ONE;
    wire [23:0] prog_two = ~tbl_wdata_in & ~written_two &
                           ~cwl_pkg::CWL_W2_FORCE_ONE;
    wire wr_one = tbl_wr_in && hit_one && loaded;
    wire wr_two = tbl_wr_in && hit_two && loaded;

    wire [23:0] rd_mux = hit_one ? w1_view :
                         hit_two ? w2_view :
                         hit_id ? id_view : 24'h000000;

    ////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_state = state;
        case (state)
            CWL_ST_IDLE: next_state = pending_por ? CWL_ST_REQ1 : CWL_ST_DONE;
            CWL_ST_REQ1: next_state = CWL_ST_WAIT1;
            CWL_ST_WAIT1: next_state = flash_valid_in ? CWL_ST_REQ2 : CWL_ST_WAIT1;
            CWL_ST_REQ2: next_state = CWL_ST_WAIT2;
            CWL_ST_WAIT2: next_state = flash_valid_in ? CWL_ST_DONE : CWL_ST_WAIT2;
            CWL_ST_DONE: next_state = CWL_ST_DONE;
            default: next_state = CWL_ST_IDLE;
        endcase
    end

    // power-on cause captured after release, never inside the reset branch
    logic por_seen;
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            por_seen <= 1'b0;
            pending_por <= 1'b0;
        end
        else if (!por_seen)
        begin
            por_seen <= 1'b1;
            pending_por <= por_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            state <= CWL_ST_IDLE;
        else if (por_seen)
            state <= next_state;
    end

    // cells are not touched by non-power-on resets
    always_ff @(posedge clk_sys_in)
    begin
        if (por_seen && state == CWL_ST_IDLE && pending_por)
        begin
            word_one <= cwl_pkg::CWL_CELL_RESET;
            word_two <= cwl_pkg::CWL_CELL_RESET;
            written_one <= 24'h000000;
            written_two <= 24'h000000;
        end
        else if (state == CWL_ST_WAIT1 && flash_valid_in)
            word_one <= flash_data_in;
        else if (state == CWL_ST_WAIT2 && flash_valid_in)
            word_two <= flash_data_in;
        else
        begin
            if (wr_one)
            begin
                word_one <= word_one & ~prog_one;
                written_one <= written_one | prog_one;
            end
            if (wr_two)
            begin
                word_two <= word_two & ~prog_two;
                written_two <= written_two | prog_two;
            end
        end
    end

    assign loaded = state == CWL_ST_DONE;

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            flash_rd_out <= 1'b0;
            flash_addr_out <= 24'h000000;
            core_reset_n_out <= 1'b0;
            tbl_ack_out <= 1'b0;
            tbl_rdata_out <= 24'h000000;
        end
        else
        begin
            flash_rd_out <= next_state == CWL_ST_REQ1 || next_state == CWL_ST_REQ2;
            flash_addr_out <= (next_state == CWL_ST_REQ2) ? w2_addr : w1_addr;
            core_reset_n_out <= next_state == CWL_ST_DONE && por_seen;
            tbl_ack_out <= loaded && (tbl_rd_in || tbl_wr_in);
            tbl_rdata_out <= (loaded && tbl_rd_in) ? rd_mux : 24'h000000;
        end
    end

    ////////////////////////////////////////////////////////////////////

    cwl_pkg::cwl_cfg_t next_cfg;
    always_comb
    begin
        next_cfg.test_port_enable = w1_view[cwl_pkg::CWL_W1_TEST_PORT];
        next_cfg.code_protect_n = w1_view[cwl_pkg::CWL_W1_CODE_PROT];
        next_cfg.write_protect_n = w1_view[cwl_pkg::CWL_W1_WRITE_PROT];
        if (!w1_view[cwl_pkg::CWL_W1_DEBUG_N])
            next_cfg.boot_mode = cwl_pkg::CWL_BOOT_DEBUG;
        else if (!w1_view[cwl_pkg::CWL_W1_EMUL_N])
            next_cfg.boot_mode = cwl_pkg::CWL_BOOT_EMULATION;
        else
            next_cfg.boot_mode = cwl_pkg::CWL_BOOT_NORMAL;
        next_cfg.debug_pin_pair_select = w1_view[cwl_pkg::CWL_W1_PIN_PAIR];
        next_cfg.watchdog_enable_cfg = w1_view[cwl_pkg::CWL_W1_WDT_EN];
        next_cfg.window_mode_disable = w1_view[cwl_pkg::CWL_W1_WIN_DIS];
        next_cfg.watchdog_prescale_select = w1_view[cwl_pkg::CWL_W1_PRESCALE];
        next_cfg.watchdog_postscale_select =
            w1_view[cwl_pkg::CWL_W1_POST_LSB +: 4];
        next_cfg.two_speed_startup_enable = w2_view[cwl_pkg::CWL_W2_TWO_SPEED];
        next_cfg.initial_osc_select =
            cwl_pkg::cwl_osc_t'(w2_view[cwl_pkg::CWL_W2_OSC_LSB +: 3]);
        next_cfg.clock_switch_enable = !w2_view[cwl_pkg::CWL_W2_SWM_LSB + 1];
        next_cfg.fail_safe_monitor_enable =
            w2_view[cwl_pkg::CWL_W2_SWM_LSB +: 2] == 2'h0;
        next_cfg.primary_osc_mode = w2_view[cwl_pkg::CWL_W2_POSC_LSB +: 2];
        next_cfg.clock_out_pin = w2_view[cwl_pkg::CWL_W2_PIN_FUNC] &&
            (next_cfg.primary_osc_mode == cwl_pkg::CWL_POSC_OFF ||
             next_cfg.primary_osc_mode == cwl_pkg::CWL_POSC_EXT_CLOCK);
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cfg_out <= '0;
            wdt_config_error_out <= 1'b0;
        end
        else if (loaded)
        begin
            cfg_out <= next_cfg;
            wdt_config_error_out <= !next_cfg.window_mode_disable &&
                                    !next_cfg.watchdog_enable_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////

    // load sequence
    a_release_after_load: assert property (
        $rose(core_reset_n_out) |-> loaded)
        else $error("internal reset released before load");
    a_fetch_word_one: assert property (
        flash_rd_out && state == CWL_ST_REQ1 |-> flash_addr_out == w1_addr)
        else $error("word 1 fetched from wrong address");
    a_fetch_word_two: assert property (
        flash_rd_out && state == CWL_ST_REQ2 |-> flash_addr_out == w1_addr - 24'h000002)
        else $error("word 2 fetched from wrong address");
    a_fetch_pulse: assert property (
        flash_rd_out |=> !flash_rd_out)
        else $error("flash request longer than one cycle");
    a_no_refetch: assert property (
        !pending_por |-> !flash_rd_out)
        else $error("flash fetched on non power-on reset");
    a_cells_reset: assert property (
        state == CWL_ST_REQ1 |-> word_one == 24'hFFFFFF && word_two == 24'hFFFFFF)
        else $error("cells not set to ones on power-on");
    a_warm_release: assert property (
        por_seen && !pending_por && state == CWL_ST_IDLE |=> loaded && core_reset_n_out)
        else $error("warm reset did not reuse held cells");
    a_por_starts_fetch: assert property (
        por_seen && pending_por && state == CWL_ST_IDLE |=> flash_rd_out)
        else $error("power-on reset did not start fetch");
    a_word_one_capture: assert property (
        state == CWL_ST_WAIT1 && flash_valid_in |=> word_one == $past(flash_data_in))
        else $error("word 1 not captured");
    a_word_two_capture: assert property (
        state == CWL_ST_WAIT2 && flash_valid_in |=> word_two == $past(flash_data_in))
        else $error("word 2 not captured");
    a_load_bound: assert property (
        $rose(flash_rd_out) && state == CWL_ST_REQ1 |-> ##[1:40] loaded)
        else $error("load did not finish");
    a_cfg_before_release: assert property (
        !core_reset_n_out && !loaded |-> cfg_out == '0)
        else $error("configuration shown before load");

    // table port
    a_no_ack_loading: assert property (
        !loaded |=> !tbl_ack_out)
        else $error("table access answered while loading");
    a_ack_follows_strobe: assert property (
        loaded && (tbl_rd_in || tbl_wr_in) |=> tbl_ack_out)
        else $error("table access not answered");
    a_rdata_idle_zero: assert property (
        !tbl_ack_out |-> tbl_rdata_out == 24'h000000)
        else $error("read data outside answer");
    a_unmapped_read: assert property (
        loaded && tbl_rd_in && !in_cfg_space |=> tbl_rdata_out == 24'h000000)
        else $error("unmapped read not zero");
    a_read_word_one: assert property (
        loaded && tbl_rd_in && hit_one |=> tbl_rdata_out == $past(w1_view))
        else $error("word 1 read wrong");
    a_forced_ones: assert property (
        tbl_ack_out && $past(tbl_rd_in && hit_one) |-> tbl_rdata_out[15] && tbl_rdata_out[9]
        && tbl_rdata_out[5])
        else $error("word 1 unimplemented bits not one");
    a_word_two_ones: assert property (
        loaded && tbl_rd_in && hit_two |=>
        (tbl_rdata_out & cwl_pkg::CWL_W2_FORCE_ONE) == cwl_pkg::CWL_W2_FORCE_ONE)
        else $error("word 2 unimplemented bits not one");
    a_upper_byte_ones: assert property (
        loaded && tbl_rd_in && (hit_one || hit_two) |=> tbl_rdata_out[23:16] == 8'hFF)
        else $error("upper byte not all ones");
    a_id_layout: assert property (
        tbl_ack_out && $past(tbl_rd_in && hit_id) |-> tbl_rdata_out == {10'h000, FAMILY_ID,
        PART_ID})
        else $error("id register read wrong");
    a_clear_only: assert property (
        wr_one || wr_two |=> (word_one & ~$past(word_one)) == 24'h000000 &&
        (word_two & ~$past(word_two)) == 24'h000000)
        else $error("table write set a cell");
    a_write_once: assert property (
        wr_one |=> ((word_one ^ $past(word_one)) & $past(written_one)) == 24'h000000)
        else $error("write-once cell changed twice");
    a_written_cleared: assert property (
        loaded |-> (written_one & word_one) == 24'h000000 &&
        (written_two & word_two) == 24'h000000)
        else $error("programmed cell reads one");

    // decoded configuration
    a_debug_wins: assert property (
        loaded && !w1_view[cwl_pkg::CWL_W1_DEBUG_N] |=>
        cfg_out.boot_mode == cwl_pkg::CWL_BOOT_DEBUG)
        else $error("debug boot not selected");
    a_window_error: assert property (
        wdt_config_error_out |-> !cfg_out.window_mode_disable && !cfg_out.watchdog_enable_cfg)
        else $error("window error without cause");
    a_clock_out_gate: assert property (
        cfg_out.clock_out_pin |-> cfg_out.primary_osc_mode inside {2'h0, 2'h3})
        else $error("clock-out pin used in crystal mode");
    a_monitor_needs_switch: assert property (
        cfg_out.fail_safe_monitor_enable |-> cfg_out.clock_switch_enable)
        else $error("monitor on without switching");

    c_power_on_load: cover property (pending_por ##[1:40] $rose(core_reset_n_out));
    c_warm_reset: cover property (!pending_por && $rose(core_reset_n_out));
    c_table_write: cover property (wr_one && prog_one != 24'h000000);
    c_debug_boot: cover property (cfg_out.boot_mode == cwl_pkg::CWL_BOOT_DEBUG);
    c_window_error: cover property (wdt_config_error_out);

endmodule : cwl_config_word_loader

/* File: src/cwl_pkg.sv */
/*
  Shared constants and types for the configuration word loader.
  Assumes a program flash read port with a fixed read latency.
*/
package cwl_pkg;

    localparam int CWL_WORD_W = 24;
    localparam int CWL_ADDR_W = 24;

    // configuration space base for table access
    localparam logic [23:0] CWL_CFG_SPACE_BASE = 24'hF80000;
    localparam logic [23:0] CWL_CFG_SPACE_LO = 24'h800000;
    localparam logic [23:0] CWL_CFG_SPACE_HI = 24'hFFFFFF;
    // table-access addresses of the volatile copies and the id register
    localparam logic [23:0] CWL_OFS_WORD_ONE = 24'hF80000;
    localparam logic [23:0] CWL_OFS_WORD_TWO = 24'hF80002;
    localparam logic [23:0] CWL_OFS_PART_ID = 24'hFF0000;

    // flash locations of word 1 for each memory size; word 2 is two below
    localparam logic [23:0] CWL_W1_ADDR_SMALL = 24'h00ABFE;
    localparam logic [23:0] CWL_W1_ADDR_MID = 24'h00FFFE;
    localparam logic [23:0] CWL_W1_ADDR_LARGE = 24'h0157FE;
    localparam logic [23:0] CWL_W2_ADDR_STEP = 24'h000002;

    localparam logic [23:0] CWL_CELL_RESET = 24'hFFFFFF;
    // bits forced to one on read: upper byte, w1 bits 15, 9, 5
    localparam logic [23:0] CWL_W1_FORCE_ONE = 24'hFF8220;
    // w2: upper byte, bits 14-11, 4-2
    localparam logic [23:0] CWL_W2_FORCE_ONE = 24'hFF781C;

    localparam int CWL_W1_TEST_PORT = 14;
    localparam int CWL_W1_CODE_PROT = 13;
    localparam int CWL_W1_WRITE_PROT = 12;
    localparam int CWL_W1_DEBUG_N = 11;
    localparam int CWL_W1_EMUL_N = 10;
    localparam int CWL_W1_PIN_PAIR = 8;
    localparam int CWL_W1_WDT_EN = 7;
    localparam int CWL_W1_WIN_DIS = 6;
    localparam int CWL_W1_PRESCALE = 4;
    localparam int CWL_W1_POST_LSB = 0;
    localparam int CWL_W2_TWO_SPEED = 15;
    localparam int CWL_W2_OSC_LSB = 8;
    localparam int CWL_W2_SWM_LSB = 6;
    localparam int CWL_W2_PIN_FUNC = 5;
    localparam int CWL_W2_POSC_LSB = 0;
    localparam int CWL_ID_FAM_LSB = 6;

    // identity codes, values arbitrary
    localparam logic [7:0] CWL_FAMILY_ID_DEFAULT = 8'h5A;
    localparam logic [5:0] CWL_PART_ID_DEFAULT = 6'h2A;

    localparam logic [1:0] CWL_POSC_EXT_CLOCK = 2'h0;
    localparam logic [1:0] CWL_POSC_OFF = 2'h3;

    typedef enum logic [2:0] {
        CWL_OSC_FAST_RC = 3'h0,
        CWL_OSC_FAST_RC_WITH_PLL = 3'h1,
        CWL_OSC_PRIMARY = 3'h2,
        CWL_OSC_PRIMARY_PLL = 3'h3,
        CWL_OSC_SECONDARY_OSC = 3'h4,
        CWL_OSC_LOW_POWER_RC = 3'h5,
        CWL_OSC_RESERVED = 3'h6,
        CWL_OSC_FAST_RC_DIVIDED = 3'h7
    } cwl_osc_t;

    typedef enum logic [1:0] {
        CWL_BOOT_NORMAL = 2'h0,
        CWL_BOOT_DEBUG = 2'h1,
        CWL_BOOT_EMULATION = 2'h2
    } cwl_boot_t;

    typedef struct packed {
        logic test_port_enable;
        logic code_protect_n;
        logic write_protect_n;
        cwl_boot_t boot_mode;
        logic debug_pin_pair_select;
        logic watchdog_enable_cfg;
        logic window_mode_disable;
        logic watchdog_prescale_select;
        logic [3:0] watchdog_postscale_select;
        logic two_speed_startup_enable;
        cwl_osc_t initial_osc_select;
        logic clock_switch_enable;
        logic fail_safe_monitor_enable;
        logic clock_out_pin;
        logic [1:0] primary_osc_mode;
    } cwl_cfg_t;

endpackage : cwl_pkg

/* File: test/cwl_config_word_loader_tb.sv */
/*
  Self-checking bench for the configuration word loader.
  Assumes the flash model above and the default identity parameters.
*/
`timescale 1ns/1ns
module cwl_config_word_loader_tb;
    logic clk = 1'b0, arst_n = 1'b0, por = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [23:0] addr = 24'h0, wd = 24'h0, w1 = 24'hFFFFFF, w2 = 24'hFFFFFF, a1;
    logic [2:0] lat = 3'h1;
    logic fv, frd, core_n, ack, werr;
    logic [23:0] fd, fa, rdat;
    cwl_pkg::cwl_cfg_t cfg;
    logic [24:0] exp_q[$];
    logic [24:0] e;
    int err_total = 0, n_tests = 0, nrd = 0, fsel = 0;
    localparam logic [23:0] W1A = cwl_pkg::CWL_W1_ADDR_MID;
    localparam logic [23:0] F1 = cwl_pkg::CWL_W1_FORCE_ONE, F2 = cwl_pkg::CWL_W2_FORCE_ONE;
    localparam logic [23:0] IDV = {10'h000, cwl_pkg::CWL_FAMILY_ID_DEFAULT,
        cwl_pkg::CWL_PART_ID_DEFAULT};
    always #2 clk = ~clk;
    cwl_config_word_loader #(.MEM_SIZE(2'h1)) dut_u (.clk_sys_in(clk), .arst_n_in(arst_n),
        .por_in(por), .flash_rd_out(frd), .flash_addr_out(fa), .flash_data_in(fd),
        .flash_valid_in(fv), .tbl_rd_in(rd), .tbl_wr_in(wr), .tbl_addr_in(addr),
        .tbl_wdata_in(wd), .tbl_rdata_out(rdat), .tbl_ack_out(ack), .core_reset_n_out(core_n),
        .cfg_out(cfg), .wdt_config_error_out(werr));
    cwl_flash_model flash_u (.clk_in(clk), .arst_n_in(arst_n), .rd_in(frd), .addr_in(fa),
        .w1_addr_in(W1A), .w1_in(w1), .w2_in(w2), .lat_in(lat), .valid_out(fv), .data_out(fd));
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv)
        begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    function automatic cwl_pkg::cwl_cfg_t dec(input logic [23:0] a, input logic [23:0] b);
        cwl_pkg::cwl_cfg_t c;
        c.test_port_enable = a[14];
        c.code_protect_n = a[13];
        c.write_protect_n = a[12];
        c.boot_mode = !a[11] ? cwl_pkg::CWL_BOOT_DEBUG
            : (!a[10] ? cwl_pkg::CWL_BOOT_EMULATION : cwl_pkg::CWL_BOOT_NORMAL);
        c.debug_pin_pair_select = a[8];
        c.watchdog_enable_cfg = a[7];
        c.window_mode_disable = a[6];
        c.watchdog_prescale_select = a[4];
        c.watchdog_postscale_select = a[3:0];
        c.two_speed_startup_enable = b[15];
        c.initial_osc_select = cwl_pkg::cwl_osc_t'(b[10:8]);
        c.clock_switch_enable = !b[7];
        c.fail_safe_monitor_enable = !b[7] && !b[6];
        c.clock_out_pin = (b[1:0] == 2'h3 || b[1:0] == 2'h0) ? b[5] : 1'b0;
        c.primary_osc_mode = b[1:0];
        return c;
    endfunction : dec
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // strobe stays up for back-to-back calls; tbl_idle drops it
    task tbl(input logic w, input logic [23:0] ad, input logic [23:0] d, input logic [24:0] ex);
        rd = !w;
        wr = w;
        addr = ad;
        wd = d;
        exp_q.push_back(ex);
        tick(1);
    endtask : tbl
    task tbl_idle;
        rd = 1'b0;
        wr = 1'b0;
        tick(3);
        check(exp_q.size(), 0);
    endtask : tbl_idle
    task do_reset(input logic p, input logic [23:0] a, input logic [23:0] b, input logic [23:0] cf);
        int i;
        arst_n = 1'b0;
        por = p;
        w1 = a;
        w2 = b;
        lat = 3'($urandom_range(5, 1));
        tick(2);
        arst_n = 1'b1;
        tick(2);
        if (p)
        begin
            check(core_n, 1'b0);
            rd = 1'b1; // refused while loading
            addr = cwl_pkg::CWL_OFS_WORD_ONE;
            tick(1);
            rd = 1'b0;
        end
        for (i = 0; i < 60 && core_n !== 1'b1; i++)
            tick(1);
        check(core_n, 1'b1);
        tick(2);
        check(cfg, dec(cf, b));
        check(werr, !cf[6] && !cf[7]);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk)
    begin
        if (ack === 1'b1)
        begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1DEAD00;
            if (e[24])
                check(rdat, e[23:0]);
        end
        if (frd === 1'b1)
        begin
            check(fa, fsel[0] ? W1A - 24'h000002 : W1A);
            fsel++;
            nrd++;
        end
    end
    initial
    begin
        #200000;
        err_total++;
        report_and_stop();
    end
    initial
    begin
        int i, n0;
        logic [23:0] a, b, m;
        void'($urandom(50));
        for (i = 0; i < 8; i++)
        begin
            a = {8'hFF, 1'b1, 15'($urandom())};
            b = {8'hFF, 5'($urandom()), 3'(i), 6'($urandom()), 2'(i)};
            do_reset(1'b1, a, b, a);
            tbl(1'b0, cwl_pkg::CWL_OFS_WORD_ONE, 24'h0, {1'b1, a | F1});
            tbl(1'b0, cwl_pkg::CWL_OFS_WORD_TWO, 24'h0, {1'b1, b | F2});
            tbl(1'b0, cwl_pkg::CWL_OFS_PART_ID, 24'h0, {1'b1, IDV});
            tbl(1'b0, 24'h001234, 24'h0, {1'b1, 24'h0});
            tbl_idle();
        end
        $display("test load and decode done");
        m = 24'($urandom());
        tbl(1'b1, cwl_pkg::CWL_OFS_WORD_ONE, m, 25'h0);
        tbl(1'b1, cwl_pkg::CWL_OFS_PART_ID, 24'h0, 25'h0);
        tbl(1'b1, cwl_pkg::CWL_OFS_WORD_ONE, 24'hFFFFFF, 25'h0);
        tbl(1'b0, cwl_pkg::CWL_OFS_WORD_ONE, 24'h0, {1'b1, (a & m) | F1});
        tbl(1'b0, cwl_pkg::CWL_OFS_PART_ID, 24'h0, {1'b1, IDV});
        tbl_idle();
        check(cfg, dec(a & m, b));
        $display("test write once done");
        n0 = nrd;
        a1 = a & m;
        do_reset(1'b0, 24'hFF0000, b, a1);
        check(nrd, n0);
        tbl(1'b0, cwl_pkg::CWL_OFS_WORD_ONE, 24'h0, {1'b1, a1 | F1});
        tbl_idle();
        $display("test warm reset done");
        do_reset(1'b1, 24'hFFFFFF, 24'hFFFFFF, 24'hFFFFFF);
        check(nrd, n0 + 2);
        tbl(1'b0, cwl_pkg::CWL_OFS_WORD_ONE, 24'h0, {1'b1, 24'hFFFFFF});
        tbl_idle();
        $display("test power-on reload done");
        report_and_stop();
    end
endmodule : cwl_config_word_loader_tb

/* File: test/cwl_flash_model.sv */
/*
  Program flash model holding the two packed configuration words.
  Assumes one read per request pulse and answers after lat_in cycles.
*/
`timescale 1ns/1ns
module cwl_flash_model (
    input wire logic clk_in, // system clock
    input wire logic arst_n_in, // async reset, active low
    input wire logic rd_in, // read request pulse
    input wire logic [23:0] addr_in, // word address
    input wire logic [23:0] w1_addr_in, // location of word 1
    input wire logic [23:0] w1_in, // stored word 1
    input wire logic [23:0] w2_in, // stored word 2
    input wire logic [2:0] lat_in, // answer delay in cycles, 1 to 7
    output logic valid_out, // data valid pulse
    output logic [23:0] data_out // read data
);
    logic [2:0] cnt;
    logic [23:0] word;
    wire logic hit_one = addr_in == w1_addr_in;
    wire logic hit_two = addr_in == w1_addr_in - 24'h000002;
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt <= 3'h0;
            valid_out <= 1'b0;
            data_out <= 24'h5A5A5A;
            word <= 24'h000000;
        end
        else
        begin
            valid_out <= 1'b0;
            data_out <= ~data_out; // stale data never holds still
            if (rd_in)
            begin
                cnt <= lat_in;
                word <= hit_one ? w1_in : (hit_two ? w2_in : ~w1_in);
            end
            else if (cnt == 3'h1)
            begin
                cnt <= 3'h0;
                valid_out <= 1'b1;
                data_out <= word;
            end
            else if (cnt != 3'h0)
                cnt <= cnt - 3'h1;
        end
    end
endmodule : cwl_flash_model
